//--- logic/rmco_pkg.sv
/*
  Shared constants of the remote terminal mode command option block:
  host register offsets, mode code numbers, self-test word flag positions
  and reset values.
  Assumes a 16-bit host address space and 5-bit mode code numbers.
*/
`default_nettype none

package rmco_pkg;

  // ----------------------------------------
  // host register offsets
  // ----------------------------------------
  localparam logic [15:0] ADDR_BUS_A_SELECT       = 16'h0012;
  localparam logic [15:0] ADDR_BUS_B_SELECT       = 16'h0013;
  localparam logic [15:0] ADDR_SELFTEST_DEFAULT   = 16'h0014;
  localparam logic [15:0] ADDR_SELFTEST_ALTERNATE = 16'h0015;

  // ----------------------------------------
  // mode code numbers
  // ----------------------------------------
  localparam logic [4:0] MC_SYNCHRONIZE     = 5'h01;
  localparam logic [4:0] MC_TX_SHUTDOWN     = 5'h04;
  localparam logic [4:0] MC_OVERRIDE        = 5'h05;
  localparam logic [4:0] MC_RESET_RT        = 5'h08;
  localparam logic [4:0] MC_TX_SELFTEST     = 5'h13;
  localparam logic [4:0] MC_SEL_SHUTDOWN    = 5'h14;
  localparam logic [4:0] MC_SEL_OVERRIDE    = 5'h15;

  // ----------------------------------------
  // shutdown flags in the default self-test word
  // ----------------------------------------
  localparam int FLAG_TX_A = 15;
  localparam int FLAG_RX_A = 14;
  localparam int FLAG_TX_B = 13;
  localparam int FLAG_RX_B = 12;
  localparam logic [11:0] USER_BITS_MASK = 12'hFFF;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] RESET_WORD    = 16'h0000;
  localparam logic [3:0]  RESET_FLAGS   = 4'h0;
  localparam logic [15:0] RESET_TIMETAG = 16'h0000;
  localparam logic [3:0]  RESET_ENABLES = 4'hF;
  localparam logic [11:0] RESET_USER    = 12'h000;

endpackage : rmco_pkg

`default_nettype wire

//--- logic/rmco_timetag.sv
/*
  Time-tag counter with a holding clear.
  Assumes tick is a one-cycle pulse synchronous to clk.
*/
`default_nettype none

module rmco_timetag #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             clear,
  input  wire logic             tick,
  output var  logic [WIDTH-1:0] count
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  // ----------------------------------------
  // counting
  // ----------------------------------------
  always_comb
  begin
    count_d = count_q;
    if (clear)
    begin
      count_d = '0;
    end
    else if (tick)
    begin
      count_d = count_q + WIDTH'(1);
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      count_q <= '0;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  assign count = count_q;

endmodule : rmco_timetag

`default_nettype wire

//--- logic/rmco_top.sv
/*
  Mode command option handling of a remote terminal: time-tag clear and
  synchronize, self-test word selection, inactive bus shutdown and override.
  Assumes mode commands arrive already validated as one-cycle strobes, and
  host register accesses as one-cycle strobes, all synchronous to clk.
*/
// Function
// - while time-tag clear bit is set, counter is held at zero
// - valid synchronize mode command clears the time-tag counter
// - select bit zero answers self-test mode command with default word
// - select bit one answers self-test mode command with alternate word
// - after shutdown, transmission on the inactive bus is inhibited
// - override, selected override, reset-terminal, master or soft reset re-enable
// - option bit zero lets the device perform shutdown and override itself
// - option bit one: selected commands change no flags; host drives transmit inhibit inputs
// - plain shutdown and override act whatever the option bit
// - shutdown disables inactive tx and rx, or tx only per scope bit
// - shutdown flags in bits 15-12 of the default self-test word
// - override re-enables inactive bus and clears its shutdown flags
// - selected commands act only when data matches inactive bus select
// - host loads distinct select values; match shuts inactive bus down
`default_nettype none

module rmco_top #(
  parameter int TT_WIDTH = 16
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                timetagClearBit,
  input  wire logic                timetagTick,
  input  wire logic                alternateSelftestWordSelect,
  input  wire logic                hostManagedShutdownOption,
  input  wire logic                shutdownScopeSelect,
  input  wire logic                softResetBit,
  input  wire logic                busATransmitInhibit,
  input  wire logic                busBTransmitInhibit,
  input  wire logic                activeBusB,
  input  wire logic                mcValid,
  input  wire logic [4:0]          mcCode,
  input  wire logic [15:0]         mcData,
  input  wire logic [15:0]         regAddr,
  input  wire logic                regWrEn,
  input  wire logic [15:0]         regWrData,
  input  wire logic                regRdEn,
  output var  logic [15:0]         regRdData,
  output var  logic                respValid,
  output var  logic [15:0]         respWord,
  output var  logic                busATxEnable,
  output var  logic                busARxEnable,
  output var  logic                busBTxEnable,
  output var  logic                busBRxEnable,
  output var  logic [TT_WIDTH-1:0] timetagCount
);

  logic [3:0]  flags_q, flags_d;
  logic [15:0] busASel_q, busASel_d;
  logic [15:0] busBSel_q, busBSel_d;
  logic [11:0] userBits_q, userBits_d;
  logic [15:0] altWord_q, altWord_d;
  logic [15:0] rdData_q, rdData_d;
  logic        respValid_q, respValid_d;
  logic [15:0] respWord_q, respWord_d;
  logic [3:0]  enables_q, enables_d;
  logic [15:0] bitWord;
  logic        syncCmd;
  logic        selMatch;
  logic        doShut;
  logic        doOver;
  logic        clearAll;

  function automatic logic isCode(input logic [4:0] code);
    isCode = mcValid && (mcCode == code);
  endfunction : isCode

  // ----------------------------------------
  // time-tag
  // ----------------------------------------
  // counter stays cleared for as long as either source asserts
  rmco_timetag #(
    .WIDTH (TT_WIDTH)
  ) u_timetag (
    .clk   (clk),
    .reset (reset),
    .clear (timetagClearBit || syncCmd),
    .tick  (timetagTick),
    .count (timetagCount)
  );

  // ----------------------------------------
  // shutdown and override
  // ----------------------------------------
  assign bitWord = {flags_q, userBits_q};

  always_comb
  begin
    // decoded in a process: a plain assign would miss changes read inside the function
    syncCmd  = isCode(rmco_pkg::MC_SYNCHRONIZE);
    selMatch = (mcData == (activeBusB ? busASel_q : busBSel_q));
    // plain commands ignore the option bit; selected ones obey it
    doShut = isCode(rmco_pkg::MC_TX_SHUTDOWN) ||
             (isCode(rmco_pkg::MC_SEL_SHUTDOWN) && !hostManagedShutdownOption && selMatch);
    doOver = isCode(rmco_pkg::MC_OVERRIDE) ||
             (isCode(rmco_pkg::MC_SEL_OVERRIDE) && !hostManagedShutdownOption && selMatch);
    clearAll = softResetBit || isCode(rmco_pkg::MC_RESET_RT);
    flags_d = flags_q;
    if (clearAll)
    begin
      flags_d = rmco_pkg::RESET_FLAGS;
    end
    else if (doOver)
    begin
      if (activeBusB)
      begin
        flags_d[rmco_pkg::FLAG_TX_A - 12] = 1'b0;
        flags_d[rmco_pkg::FLAG_RX_A - 12] = 1'b0;
      end
      else
      begin
        flags_d[rmco_pkg::FLAG_TX_B - 12] = 1'b0;
        flags_d[rmco_pkg::FLAG_RX_B - 12] = 1'b0;
      end
    end
    else if (doShut)
    begin
      if (activeBusB)
      begin
        flags_d[rmco_pkg::FLAG_TX_A - 12] = 1'b1;
        flags_d[rmco_pkg::FLAG_RX_A - 12] = !shutdownScopeSelect | flags_q[rmco_pkg::FLAG_RX_A - 12];
      end
      else
      begin
        flags_d[rmco_pkg::FLAG_TX_B - 12] = 1'b1;
        flags_d[rmco_pkg::FLAG_RX_B - 12] = !shutdownScopeSelect | flags_q[rmco_pkg::FLAG_RX_B - 12];
      end
    end
    // enables follow new flags; host inhibits apply on top
    enables_d = {!flags_d[rmco_pkg::FLAG_TX_A - 12] && !busATransmitInhibit,
                 !flags_d[rmco_pkg::FLAG_RX_A - 12],
                 !flags_d[rmco_pkg::FLAG_TX_B - 12] && !busBTransmitInhibit,
                 !flags_d[rmco_pkg::FLAG_RX_B - 12]};
  end

  // ----------------------------------------
  // host registers and self-test answer
  // ----------------------------------------
  always_comb
  begin
    busASel_d  = busASel_q;
    busBSel_d  = busBSel_q;
    userBits_d = userBits_q;
    altWord_d  = altWord_q;
    if (regWrEn)
    begin
      case (regAddr)
        rmco_pkg::ADDR_BUS_A_SELECT:       busASel_d = regWrData;
        rmco_pkg::ADDR_BUS_B_SELECT:       busBSel_d = regWrData;
        rmco_pkg::ADDR_SELFTEST_DEFAULT:   userBits_d = regWrData[11:0] & rmco_pkg::USER_BITS_MASK;
        rmco_pkg::ADDR_SELFTEST_ALTERNATE: altWord_d = regWrData;
        default:                           busASel_d = busASel_q;
      endcase
    end
    rdData_d = rdData_q;
    if (regRdEn)
    begin
      case (regAddr)
        rmco_pkg::ADDR_BUS_A_SELECT:       rdData_d = busASel_q;
        rmco_pkg::ADDR_BUS_B_SELECT:       rdData_d = busBSel_q;
        rmco_pkg::ADDR_SELFTEST_DEFAULT:   rdData_d = bitWord;
        rmco_pkg::ADDR_SELFTEST_ALTERNATE: rdData_d = altWord_q;
        default:                           rdData_d = rmco_pkg::RESET_WORD;
      endcase
    end
    respValid_d = isCode(rmco_pkg::MC_TX_SELFTEST);
    respWord_d  = respWord_q;
    if (respValid_d)
    begin
      respWord_d = alternateSelftestWordSelect ? altWord_q : bitWord;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      flags_q     <= rmco_pkg::RESET_FLAGS;
      enables_q   <= rmco_pkg::RESET_ENABLES;
      busASel_q   <= rmco_pkg::RESET_WORD;
      busBSel_q   <= rmco_pkg::RESET_WORD;
      userBits_q  <= rmco_pkg::RESET_USER;
      altWord_q   <= rmco_pkg::RESET_WORD;
      rdData_q    <= rmco_pkg::RESET_WORD;
      respValid_q <= 1'b0;
      respWord_q  <= rmco_pkg::RESET_WORD;
    end
    else
    begin
      flags_q     <= flags_d;
      enables_q   <= enables_d;
      busASel_q   <= busASel_d;
      busBSel_q   <= busBSel_d;
      userBits_q  <= userBits_d;
      altWord_q   <= altWord_d;
      rdData_q    <= rdData_d;
      respValid_q <= respValid_d;
      respWord_q  <= respWord_d;
    end
  end

  assign regRdData    = rdData_q;
  assign respValid    = respValid_q;
  assign respWord     = respWord_q;
  assign busATxEnable = enables_q[3];
  assign busARxEnable = enables_q[2];
  assign busBTxEnable = enables_q[1];
  assign busBRxEnable = enables_q[0];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  tt_clear_a: assert property (timetagClearBit |=> timetagCount == '0)
    else $error("time-tag not held at zero");
  tt_sync_a: assert property (syncCmd |=> timetagCount == '0)
    else $error("synchronize did not clear time-tag");
  tt_resume_a: assert property (!timetagClearBit && !syncCmd && timetagTick
      && timetagCount == '0 |=> timetagCount == TT_WIDTH'(1))
    else $error("time-tag did not resume from zero");
  bit_default_a: assert property (mcValid && mcCode == rmco_pkg::MC_TX_SELFTEST
      && !alternateSelftestWordSelect |=> respValid && respWord == $past(bitWord))
    else $error("default self-test word not answered");
  bit_alt_a: assert property (mcValid && mcCode == rmco_pkg::MC_TX_SELFTEST
      && alternateSelftestWordSelect |=> respValid && respWord == $past(altWord_q))
    else $error("alternate self-test word not answered");
  tx_inhibit_a: assert property (flags_q[rmco_pkg::FLAG_TX_B - 12] |-> !busBTxEnable)
    else $error("shut-down bus B still transmits");
  soft_reset_a: assert property (softResetBit |=> flags_q == rmco_pkg::RESET_FLAGS
      && (busATxEnable || $past(busATransmitInhibit)) && busARxEnable && busBRxEnable)
    else $error("soft reset did not re-enable");
  plain_shut_a: assert property (mcValid && mcCode == rmco_pkg::MC_TX_SHUTDOWN
      && !softResetBit && !activeBusB |=> flags_q[rmco_pkg::FLAG_TX_B - 12] && !busBTxEnable)
    else $error("plain shutdown not fulfilled");
  scope_a: assert property (doShut && !doOver && !clearAll && shutdownScopeSelect
      && !activeBusB |=> flags_q[rmco_pkg::FLAG_RX_B - 12] == $past(flags_q[0]))
    else $error("receiver shut in transmitter-only scope");
  override_a: assert property (mcValid && mcCode == rmco_pkg::MC_OVERRIDE && !activeBusB
      |=> flags_q[1:0] == 2'b00 && busBRxEnable)
    else $error("override did not clear inactive flags");
  host_opt_a: assert property (mcValid && mcCode == rmco_pkg::MC_SEL_SHUTDOWN
      && (hostManagedShutdownOption || !selMatch) && !softResetBit |=> $stable(flags_q))
    else $error("selected shutdown acted when it must not");

  shut_c: cover property (mcValid && mcCode == rmco_pkg::MC_TX_SHUTDOWN ##1 !busBTxEnable);
  sel_c: cover property (mcValid && mcCode == rmco_pkg::MC_SEL_SHUTDOWN && selMatch
      && !hostManagedShutdownOption);
  alt_c: cover property (respValid && alternateSelftestWordSelect);
  over_c: cover property (mcValid && mcCode == rmco_pkg::MC_SEL_OVERRIDE && flags_q != 4'h0);

endmodule : rmco_top

`default_nettype wire

//--- testbench/rmco_bc_model.sv
/*
  Bus controller model: issues validated mode commands as one-cycle strobes.
  Assumes the caller enters send just after a falling clock edge.
*/
`default_nettype none

module rmco_bc_model (
  output var  logic        mcValid,
  output var  logic [4:0]  mcCode,
  output var  logic [15:0] mcData,
  input  wire logic        clk
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    mcValid = 1'b0;
    mcCode  = 5'h00;
    mcData  = 16'h5A5A;
  end

  task automatic send(input logic [4:0] code, input logic [15:0] data);
    mcValid = 1'b1;
    mcCode  = code;
    mcData  = data;
    @(negedge clk);
    mcValid = 1'b0;
    // scrambled once released, so a stale word cannot match
    mcData  = ~data;
  endtask : send

endmodule : rmco_bc_model

`default_nettype wire

//--- testbench/rt_mode_command_options_tb.sv
/*
  Self-checking bench of the mode command option block against a reference model.
  Assumes the bus controller model drives the mode command strobe.
*/
`default_nettype none

module rt_mode_command_options_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, reset, ttClr, tick, altSel, hostOpt, scope, softRst;
  logic        inhA, inhB, actB, mcValid, regWrEn, regRdEn, respValid;
  logic        aTx, aRx, bTx, bRx;
  logic [4:0]  mcCode;
  logic [4:0]  codes [7];
  logic [15:0] mcData, regAddr, regWrData, regRdData, respWord, ttCount;
  logic [15:0] selA, selB, altWord, d;
  logic [11:0] userBits;
  logic [3:0]  flags;
  int          err_count, n_compared, tt, i, seed;

  rmco_top dut (.clk(clk), .reset(reset), .timetagClearBit(ttClr), .timetagTick(tick),
    .alternateSelftestWordSelect(altSel), .hostManagedShutdownOption(hostOpt),
    .shutdownScopeSelect(scope), .softResetBit(softRst), .busATransmitInhibit(inhA),
    .busBTransmitInhibit(inhB), .activeBusB(actB), .mcValid(mcValid), .mcCode(mcCode),
    .mcData(mcData), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData), .respValid(respValid), .respWord(respWord),
    .busATxEnable(aTx), .busARxEnable(aRx), .busBTxEnable(bTx), .busBRxEnable(bRx),
    .timetagCount(ttCount));

  rmco_bc_model bc (.mcValid(mcValid), .mcCode(mcCode), .mcData(mcData), .clk(clk));

  always #10 clk = ~clk;

  task automatic chkWord(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chkWord

  task automatic chkBus();
    logic [3:0] exp;
    exp = {~flags[3] & ~inhA, ~flags[2], ~flags[1] & ~inhB, ~flags[0]};
    chkWord("bus enables", {12'h000, exp}, {12'h000, aTx, aRx, bTx, bRx});
  endtask : chkBus

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    regAddr   = a;
    regWrData = v;
    regWrEn   = 1'b1;
    @(negedge clk);
    regWrEn   = 1'b0;
    // idle cycle so a following write never re-raises the strobe in the same step
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    chkWord("read data", exp, regRdData);
    @(negedge clk);
  endtask : rd

  task automatic ticks(input int n);
    repeat (n)
    begin
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
      @(negedge clk);
      if (!ttClr)
        tt++;
    end
    chkWord("timetag", 16'(tt), ttCount);
  endtask : ticks

  task automatic mc(input logic [4:0] c, input logic [15:0] v);
    logic [3:0] txm, rxm;
    logic       hit, ovr;
    txm = actB ? 4'h8 : 4'h2;
    rxm = actB ? 4'h4 : 4'h1;
    ovr = (c == rmco_pkg::MC_OVERRIDE) || (c == rmco_pkg::MC_SEL_OVERRIDE);
    hit = (c == rmco_pkg::MC_SEL_SHUTDOWN || c == rmco_pkg::MC_SEL_OVERRIDE) && !hostOpt
          && (v === (actB ? selA : selB));
    hit = hit || (c == rmco_pkg::MC_TX_SHUTDOWN) || (c == rmco_pkg::MC_OVERRIDE);
    bc.send(c, v);
    chkWord("resp valid", {15'h0, c == rmco_pkg::MC_TX_SELFTEST}, {15'h0, respValid});
    if (c == rmco_pkg::MC_TX_SELFTEST)
      chkWord("resp word", altSel ? altWord : {flags, userBits}, respWord);
    if (c == rmco_pkg::MC_SYNCHRONIZE)
      tt = 0;
    if (c == rmco_pkg::MC_RESET_RT)
      flags = 4'h0;
    else if (hit && ovr)
      flags &= ~(txm | rxm);
    else if (hit)
      flags |= txm | (scope ? 4'h0 : rxm);
    chkWord("timetag", 16'(tt), ttCount);
    chkBus();
    rd(rmco_pkg::ADDR_SELFTEST_DEFAULT, {flags, userBits});
  endtask : mc

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // ----------------------------------------
  // stimulus and checks
  // ----------------------------------------
  initial
  begin
    #200000;
    err_count++;
    results();
  end

  initial
  begin
    clk   = 1'b0;
    reset = 1'b1;
    {ttClr, tick, altSel, hostOpt, scope, softRst, inhA, inhB, actB, regWrEn, regRdEn} = '0;
    regAddr    = 16'h0000;
    regWrData  = 16'h0000;
    err_count  = 0;
    n_compared = 0;
    tt         = 0;
    flags      = 4'h0;
    codes = '{rmco_pkg::MC_SYNCHRONIZE, rmco_pkg::MC_TX_SHUTDOWN, rmco_pkg::MC_OVERRIDE,
              rmco_pkg::MC_RESET_RT, rmco_pkg::MC_TX_SELFTEST, rmco_pkg::MC_SEL_SHUTDOWN,
              rmco_pkg::MC_SEL_OVERRIDE};
    seed = $urandom(58);
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    chkBus();
    selA     = 16'($urandom);
    selB     = ~selA;
    altWord  = 16'($urandom);
    userBits = 12'($urandom);
    wr(rmco_pkg::ADDR_BUS_A_SELECT, selA);
    wr(rmco_pkg::ADDR_BUS_B_SELECT, selB);
    wr(rmco_pkg::ADDR_SELFTEST_ALTERNATE, altWord);
    wr(rmco_pkg::ADDR_SELFTEST_DEFAULT, {4'hF, userBits});
    wr(16'h0016, 16'hFFFF);
    rd(rmco_pkg::ADDR_BUS_A_SELECT, selA);
    rd(rmco_pkg::ADDR_BUS_B_SELECT, selB);
    rd(rmco_pkg::ADDR_SELFTEST_ALTERNATE, altWord);
    rd(rmco_pkg::ADDR_SELFTEST_DEFAULT, {4'h0, userBits});
    rd(16'h0016, 16'h0000);
    ticks(5);
    ttClr = 1'b1;
    tt    = 0;
    ticks(3);
    ttClr = 1'b0;
    ticks(2);
    for (i = 0; i < 70; i++)
    begin
      {actB, scope, hostOpt, altSel, inhA, inhB} = 6'($urandom);
      d = (i % 3 == 0) ? selA : (i % 3 == 1) ? selB : 16'($urandom);
      mc(i < 7 ? codes[i] : codes[$urandom % 7], d);
      if (i % 9 == 8)
      begin
        softRst = 1'b1;
        @(negedge clk);
        softRst = 1'b0;
        flags   = 4'h0;
        chkBus();
      end
    end
    mc(rmco_pkg::MC_TX_SHUTDOWN, 16'h0000);
    // enables read all high under reset, so host inhibits must be off here
    {inhA, inhB} = 2'b00;
    reset = 1'b1;
    @(negedge clk);
    reset    = 1'b0;
    flags    = 4'h0;
    userBits = 12'h000;
    chkBus();
    rd(rmco_pkg::ADDR_SELFTEST_DEFAULT, 16'h0000);
    results();
  end

endmodule : rt_mode_command_options_tb

`default_nettype wire
